// ---- design/sqd_dev.sv ----
// Purpose: memory end of the burst-of-two link: DLL lock, read and
//          write state machines, read data timing
// Assumes: pins arrive asynchronously and are resynchronised
// Notes:   storage holds DEPTH words addressed by low address bits
//
// Operation
// - lock wait after stable clocks before use
// - DLL disabled: ready after lock wait anyway
// - controller resets DLL if disable released early
// - K still over 30 ns resets DLL; here only after STOP_LIMIT still mclk cycles (300 ns)
// - disable pin rising edge resets DLL
// - controller resets DLL on frequency change
// - controller holds all pins defined at power-on
// - burst of two, second address plus one
// - read when read select low at K rise
// - write when write select low at K rise
// - read and write machines run independently
// - machines sequence only on K rise; here a K-bar rise also steps the read pipe and the write
// - first read word at C-bar, t+1.5
// - second read word at C, t+2.0
// - controller gives first write word at K
// - controller gives second write word at K-bar
// - output clocks may be delayed by system
// - lock after 2048 stable K cycles
// - DLL off: one cycle read latency
// - output clocks tied high: K times outputs
`timescale 1ns/100ps
module sqd_dev #(
    parameter int unsigned LOCK_CYCLES = sqd_pkg::LOCK_CYCLES_DEF
) (
    input wire logic mclk,      // system clock
    input wire logic rst,       // async reset, high
    sqd_link_if.dev link,       // pins toward the controller
    output logic dll_ready,     // lock wait finished
    output logic dll_on         // DLL in use, disable pin high
);
    import sqd_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] prev;
        sqd_dll_e dll;
        logic [CNT_W-1:0] lcnt;
        logic [CNT_W-1:0] scnt;
        logic dll_on;
        logic [PIPE_N-1:0] pv;
        logic [PIPE_N-1:0][MEM_AW-1:0] pa;
        logic wpend;
        sqd_data_t wd0;
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        sqd_data_t q;
        logic q_vld;
        logic q_new;
    } sqd_dev_s;

    sqd_dev_s s_q;
    sqd_dev_s s_d;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_f;

    // ==========================================================
    // pin capture
    // all pins share one synchroniser so a command and its K edge
    // are always seen in the same mclk cycle
    assign pins_raw = {link.k, link.kn, link.c, link.cn, link.r_n,
                       link.w_n, link.doff_n, link.addr, link.d};

    sqd_sync3 #(
        .W(PIN_W)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din(pins_raw),
        .dout(pins_f)
    );

    // ==========================================================
    // next state
    always_comb begin
        sqd_pins_s cur;
        sqd_pins_s prv;
        logic k_r;
        logic kn_r;
        logic k_move;
        logic tied;
        logic o_p;
        logic o_n;
        logic dll_rst;
        logic ready;
        sqd_maddr_t ra;
        sqd_maddr_t wa;
        ra = '0;
        wa = '0;
        cur = sqd_pins_s'(pins_f);
        prv = sqd_pins_s'(s_q.prev);
        s_d = s_q;
        s_d.prev = pins_f;
        s_d.q_new = 1'h0;

        // edges of the input clock pair
        k_r = sqd_rise(cur.k, prv.k);
        kn_r = sqd_rise(cur.kn, prv.kn);
        k_move = (cur.k != prv.k) || (cur.kn != prv.kn);

        // output clocks tied high hand their job to K and K-bar
        tied = cur.c & cur.cn;
        o_p = tied ? k_r : sqd_rise(cur.c, prv.c);
        o_n = tied ? kn_r : sqd_rise(cur.cn, prv.cn);

        // ------------------------------------------------------
        // clock stop watch: both K pins still too long
        if (k_move) begin
            s_d.scnt = '0;
        end else if (s_q.scnt < CNT_W'(STOP_LIMIT)) begin
            s_d.scnt = s_q.scnt + CNT_ONE;
        end
        dll_rst = (!k_move && s_q.scnt == CNT_W'(STOP_LIMIT - 1));
        // a low to high move on the disable pin restarts the lock
        dll_rst = dll_rst | sqd_rise(cur.doff_n, prv.doff_n);

        // mode follows the disable pin; low changes read timing only
        s_d.dll_on = cur.doff_n;

        // ------------------------------------------------------
        // lock wait, counted in K rises of stable clock
        if (dll_rst) begin
            s_d.dll = DLL_LOCKING;
            s_d.lcnt = '0;
        end else begin
            case (s_q.dll)
                DLL_LOCKING: begin
                    if (k_r) begin
                        s_d.lcnt = s_q.lcnt + CNT_ONE;
                        if (s_d.lcnt == CNT_W'(LOCK_CYCLES)) begin
                            s_d.dll = DLL_READY;
                        end
                    end
                end
                DLL_READY: begin
                    s_d.dll = DLL_READY;
                end
                default: begin
                    s_d.dll = DLL_LOCKING;
                end
            endcase
        end
        // commands before the lock wait ends are not served
        ready = (s_q.dll == DLL_READY) && !dll_rst;

        // ------------------------------------------------------
        // read machine: a pipe of half K cycles since each read
        // every half step is a K or K-bar rise, so both time it
        if (k_r || kn_r) begin
            s_d.pv = {s_q.pv[PIPE_N-2:0], 1'h0};
            s_d.pa = {s_q.pa[PIPE_N-2:0], {MEM_AW{1'h0}}};
        end
        if (k_r && ready && !cur.r_n) begin
            s_d.pv[0] = 1'h1;
            s_d.pa[0] = cur.addr[MEM_AW-1:0];
        end

        // ------------------------------------------------------
        // read data out, taken at output clock edges
        // a pause in reads leaves the pins undriven (q_vld low)
        if (o_p || o_n) begin
            s_d.q_vld = 1'h0;
        end
        if (s_d.dll_on) begin
            if (o_n && s_d.pv[STG_ON_B0]) begin
                ra = s_d.pa[STG_ON_B0];
                s_d.q = s_q.mem[ra];
                s_d.q_vld = 1'h1;
                s_d.q_new = 1'h1;
            end
            if (o_p && s_d.pv[STG_ON_B1]) begin
                ra = sqd_burst_next(s_d.pa[STG_ON_B1]);
                s_d.q = s_q.mem[ra];
                s_d.q_vld = 1'h1;
                s_d.q_new = 1'h1;
            end
        end else begin
            // DLL bypassed: one cycle latency, beats at t+1, t+1.5
            if (o_p && s_d.pv[STG_OFF_B0]) begin
                ra = s_d.pa[STG_OFF_B0];
                s_d.q = s_q.mem[ra];
                s_d.q_vld = 1'h1;
                s_d.q_new = 1'h1;
            end
            if (o_n && s_d.pv[STG_OFF_B1]) begin
                ra = sqd_burst_next(s_d.pa[STG_OFF_B1]);
                s_d.q = s_q.mem[ra];
                s_d.q_vld = 1'h1;
                s_d.q_new = 1'h1;
            end
        end

        // ------------------------------------------------------
        // write machine: first word with the K rise, address and
        // second word with the following K-bar rise
        if (k_r && ready && !cur.w_n) begin
            s_d.wpend = 1'h1;
            s_d.wd0 = cur.d;
        end
        if (kn_r && s_q.wpend) begin
            wa = cur.addr[MEM_AW-1:0];
            s_d.mem[wa] = s_q.wd0;
            s_d.mem[sqd_burst_next(wa)] = cur.d;
            s_d.wpend = 1'h0;
        end
    end

    // ==========================================================
    // state register; a stopped clock simply freezes the pipes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from the state register
    assign link.q = s_q.q;
    assign link.q_vld = s_q.q_vld;
    assign link.q_new = s_q.q_new;
    assign dll_ready = (s_q.dll == DLL_READY);
    assign dll_on = s_q.dll_on;
endmodule // sqd_dev

// ---- design/sqd_pkg.sv ----
// Purpose: shared constants and types for the burst-of-two memory link
// Assumes: one system clock mclk at 10 MHz drives both ends
// Notes:   the link clock K is made by the controller from mclk
package sqd_pkg;
    // ==========================================================
    // widths and storage
    localparam int DATA_W = 36;
    localparam int ADDR_W = 20;
    localparam int MEM_AW = 4;
    localparam int DEPTH = 16;
    localparam int CNT_W = 16;
    localparam int PH_W = 2;

    // ==========================================================
    // timing
    localparam int CLK_NS = 100;
    localparam int KSTOP_NS = 30;
    // least time, rounded up, never below one cycle
    localparam int KSTOP_CYC_RAW = (KSTOP_NS + CLK_NS - 1) / CLK_NS;
    localparam int KSTOP_CYC = (KSTOP_CYC_RAW < 1) ? 1 : KSTOP_CYC_RAW;
    // mclk cycles per half period of K
    localparam int K_HALF = 2;
    // a still K only counts as stopped beyond its own half period
    localparam int STOP_LIMIT = KSTOP_CYC + K_HALF;
    localparam int LOCK_CYCLES_DEF = 2048;
    localparam int DOFF_LOW_CYC = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ==========================================================
    // K phase positions inside one K period of four mclk cycles
    localparam logic [PH_W-1:0] PH_KRISE = 2'h0;
    localparam logic [PH_W-1:0] PH_KNRISE = 2'h2;
    localparam logic [PH_W-1:0] PH_ONE = 2'h1;

    // ==========================================================
    // read pipeline in half K cycles after the command
    localparam int PIPE_N = 5;
    localparam int STG_ON_B0 = 3;
    localparam int STG_ON_B1 = 4;
    localparam int STG_OFF_B0 = 2;
    localparam int STG_OFF_B1 = 3;

    typedef logic [DATA_W-1:0] sqd_data_t;
    typedef logic [ADDR_W-1:0] sqd_addr_t;
    typedef logic [MEM_AW-1:0] sqd_maddr_t;

    // every pin the controller drives toward the memory
    typedef struct packed {
        logic k;
        logic kn;
        logic c;
        logic cn;
        logic r_n;
        logic w_n;
        logic doff_n;
        sqd_addr_t addr;
        sqd_data_t d;
    } sqd_pins_s;
    localparam int PIN_W = $bits(sqd_pins_s);

    typedef enum logic [1:0] {
        DLL_LOCKING = 2'h0,
        DLL_READY = 2'h1
    } sqd_dll_e;

    typedef enum logic [1:0] {
        CTL_WAIT = 2'h0,
        CTL_READY = 2'h1,
        CTL_DOFF_LOW = 2'h3
    } sqd_ctl_e;

    // second beat of a burst: linear, one above the first
    function automatic sqd_maddr_t sqd_burst_next(input sqd_maddr_t a);
        return a + 4'h1;
    endfunction

    // rising edge of a level seen on two successive cycles
    function automatic logic sqd_rise(input logic cur, input logic prv);
        return cur & ~prv;
    endfunction
endpackage

// ---- design/sqd_link_if.sv ----
// Purpose: pins between the memory controller and the memory
// Assumes: all pins are plain levels on the board
// Notes:   output-only data pins, so no turnaround is modelled
`timescale 1ns/100ps
interface sqd_link_if;
    import sqd_pkg::*;
    // ==========================================================
    // controller to memory
    logic k;
    logic kn;
    logic c;
    logic cn;
    logic r_n;
    logic w_n;
    logic doff_n;
    sqd_addr_t addr;
    sqd_data_t d;
    // ==========================================================
    // memory to controller
    sqd_data_t q;
    logic q_vld;
    logic q_new;

    modport dev (
        input k, kn, c, cn, r_n, w_n, doff_n, addr, d,
        output q, q_vld, q_new
    );
    modport ctl (
        output k, kn, c, cn, r_n, w_n, doff_n, addr, d,
        input q, q_vld, q_new
    );
endinterface

// ---- design/sqd_sync3.sv ----
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: the whole vector is sampled together
// Notes:   each output bit moves once its stages two and three agree
`timescale 1ns/100ps
module sqd_sync3 #(
    parameter int W = 1
) (
    input wire logic mclk,         // system clock
    input wire logic rst,          // async reset, high
    input wire logic [W-1:0] din,  // raw pins
    output logic [W-1:0] dout      // filtered pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } sqd_sync_s;

    sqd_sync_s s_q;
    sqd_sync_s s_d;

    // ==========================================================
    // stage one feeds only stage two, so metastability stays put
    always_comb begin
        s_d = s_q;
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // each bit moves on its own once its stages two and three
        // agree; a whole-vector test would stall whenever some bit
        // toggles in every cycle, as K and the trailing output clocks do
        s_d.o = (s_q.o & (s_q.s2 ^ s_q.s3))
            | (s_q.s3 & ~(s_q.s2 ^ s_q.s3));
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.o;
endmodule // sqd_sync3

// ---- design/sqd_ctl.sv ----
// Purpose: controller end: makes K, C, disable pin, commands, and
//          collects read bursts
// Assumes: memory answers on the same mclk, so no resync of q
// Notes:   K period is four mclk cycles
`timescale 1ns/100ps
module sqd_ctl #(
    parameter int unsigned LOCK_CYCLES = sqd_pkg::LOCK_CYCLES_DEF
) (
    input wire logic mclk,              // system clock
    input wire logic rst,               // async reset, high
    sqd_link_if.ctl link,               // pins toward the memory
    input wire logic clk_stop,          // hold K still
    input wire logic single_clk,        // tie C and C-bar high
    input wire logic dll_off,           // hold disable pin low
    input wire logic dll_reset_req,     // pulse: toggle disable pin
    input wire logic rd_req,            // read request, level
    input wire sqd_pkg::sqd_addr_t rd_addr,  // read address
    input wire logic wr_req,            // write request, level
    input wire sqd_pkg::sqd_addr_t wr_addr,  // write address
    input wire sqd_pkg::sqd_data_t wr_d0,    // first write word
    input wire sqd_pkg::sqd_data_t wr_d1,    // second write word
    output logic ready,                 // lock wait done
    output logic cmd_ack,               // pulse: requests issued
    output logic rd_done,               // pulse: burst collected
    output sqd_pkg::sqd_data_t rd_d0,   // first read word
    output sqd_pkg::sqd_data_t rd_d1    // second read word
);
    import sqd_pkg::*;

    typedef struct packed {
        sqd_pins_s p;
        logic [PH_W-1:0] ph;
        sqd_ctl_e st;
        logic [CNT_W-1:0] cnt;
        sqd_addr_t wa;
        sqd_data_t wd1;
        logic ack;
        logic beat;
        sqd_data_t rd0;
        sqd_data_t rd1;
        logic done;
    } sqd_ctl_s;

    sqd_ctl_s s_q;
    sqd_ctl_s s_d;

    // ==========================================================
    // next state
    always_comb begin
        logic krise;
        logic knrise;
        s_d = s_q;
        s_d.ack = 1'h0;
        s_d.done = 1'h0;
        krise = 1'h0;
        knrise = 1'h0;

        // K divider; a stop freezes both pins at their level
        if (!clk_stop) begin
            s_d.ph = s_q.ph + PH_ONE;
            krise = (s_d.ph == PH_KRISE);
            knrise = (s_d.ph == PH_KNRISE);
        end
        s_d.p.k = (s_d.ph < PH_KNRISE);
        s_d.p.kn = ~s_d.p.k;
        // output clocks trail K by one mclk for capture margin
        s_d.p.c = single_clk | s_q.p.k;
        s_d.p.cn = single_clk | s_q.p.kn;
        s_d.p.doff_n = ~dll_off;

        // ------------------------------------------------------
        // lock wait bookkeeping
        case (s_q.st)
            CTL_WAIT: begin
                if (krise) begin
                    s_d.cnt = s_q.cnt + CNT_ONE;
                    if (s_d.cnt == CNT_W'(LOCK_CYCLES)) begin
                        s_d.st = CTL_READY;
                    end
                end
            end
            CTL_READY: begin
                s_d.st = CTL_READY;
            end
            CTL_DOFF_LOW: begin
                s_d.p.doff_n = 1'h0;
                s_d.cnt = s_q.cnt + CNT_ONE;
                if (s_d.cnt == CNT_W'(DOFF_LOW_CYC)) begin
                    s_d.st = CTL_WAIT;
                    s_d.cnt = '0;
                end
            end
            default: begin
                s_d.st = CTL_WAIT;
            end
        endcase
        // a toggle request, a stop or a fresh release all relock
        if (dll_reset_req && s_q.st != CTL_DOFF_LOW) begin
            s_d.st = CTL_DOFF_LOW;
            s_d.p.doff_n = 1'h0;
            s_d.cnt = '0;
        end else if (clk_stop || (s_d.p.doff_n && !s_q.p.doff_n)) begin
            s_d.st = CTL_WAIT;
            s_d.cnt = '0;
        end

        // ------------------------------------------------------
        // commands: read address and first word with K, write
        // address and second word with K-bar
        if (krise) begin
            s_d.p.r_n = ~(rd_req && s_q.st == CTL_READY);
            s_d.p.w_n = ~(wr_req && s_q.st == CTL_READY);
            s_d.p.addr = rd_addr;
            s_d.p.d = wr_d0;
            s_d.wa = wr_addr;
            s_d.wd1 = wr_d1;
            s_d.ack = (rd_req || wr_req) && s_q.st == CTL_READY;
        end else if (knrise) begin
            s_d.p.r_n = 1'h1;
            s_d.p.w_n = 1'h1;
            s_d.p.addr = s_q.wa;
            s_d.p.d = s_q.wd1;
        end

        // ------------------------------------------------------
        // read capture, first word then second
        if (link.q_new && link.q_vld) begin
            if (!s_q.beat) begin
                s_d.rd0 = link.q;
                s_d.beat = 1'h1;
            end else begin
                s_d.rd1 = link.q;
                s_d.beat = 1'h0;
                s_d.done = 1'h1;
            end
        end
    end

    // ==========================================================
    // reset leaves every pin at a defined level, selects inactive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.p.r_n <= 1'h1;
            s_q.p.w_n <= 1'h1;
            s_q.p.kn <= 1'h1;
            s_q.ph <= PH_KNRISE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign link.k = s_q.p.k;
    assign link.kn = s_q.p.kn;
    assign link.c = s_q.p.c;
    assign link.cn = s_q.p.cn;
    assign link.r_n = s_q.p.r_n;
    assign link.w_n = s_q.p.w_n;
    assign link.doff_n = s_q.p.doff_n;
    assign link.addr = s_q.p.addr;
    assign link.d = s_q.p.d;
    assign ready = (s_q.st == CTL_READY);
    assign cmd_ack = s_q.ack;
    assign rd_done = s_q.done;
    assign rd_d0 = s_q.rd0;
    assign rd_d1 = s_q.rd1;
endmodule // sqd_ctl

// ---- verification/sqd_link_properties.sv ----
// Purpose: pin checks on the link between controller and memory
// Assumes: K period of four mclk, commands only while both ends lock
// Notes:   user sides are judged by the bench, not here
`timescale 1ns/100ps
module sqd_link_properties (
    input wire logic mclk,             // system clock
    input wire logic rst,              // async reset, high
    input wire logic k,                // input clock
    input wire logic kn,               // input clock, inverse
    input wire logic c,                // output clock
    input wire logic cn,               // output clock, inverse
    input wire logic r_n,              // read select
    input wire logic w_n,              // write select
    input wire logic doff_n,           // dll disable
    input wire sqd_pkg::sqd_addr_t addr, // address
    input wire sqd_pkg::sqd_data_t d,  // write data
    input wire sqd_pkg::sqd_data_t q,  // read data
    input wire logic q_vld,            // read word valid
    input wire logic q_new             // read word taken
);
    import sqd_pkg::*;
    // ==========================================================
    // link timing
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_k_pair_inverse: assert property (kn == !k)
        else $error("k pair not complementary");
    // output clocks trail k by one cycle unless both are tied high
    a_c_follows_k: assert property ((c != cn) |-> c == $past(k))
        else $error("output clock not one cycle behind k");
    a_rd_select_k: assert property (
        $fell(r_n) |-> $rose(k) ##1 !r_n ##1 r_n)
        else $error("read select not a k rise of two cycles");
    a_wr_first_word: assert property (
        $fell(w_n) |-> $rose(k) ##1 ($stable(d) && $stable(addr))
        ##1 ($fell(k) && w_n))
        else $error("first write word not held through k high");
    a_wr_second_word: assert property ($fell(w_n) |-> ##3 $stable(d))
        else $error("second write word not held through k low");
    a_rd_answer_bound: assert property (
        $fell(r_n) |-> ##[4:14] q_new)
        else $error("read word missing after read select");
    a_new_word_valid: assert property (q_new |-> q_vld)
        else $error("new read word without valid");
    a_q_change_marked: assert property (
        (q_vld && $changed(q)) |-> q_new)
        else $error("read data moved without new word pulse");
    c_dll_off_read: cover property (!doff_n && $fell(r_n));
endmodule // sqd_link_properties

// ---- verification/sync_sram_init_and_burst_ops_tb.sv ----
// Purpose: end to end bench for controller and memory ends
// Assumes: mclk 10 MHz, lock wait shortened to LK k cycles
// Notes:   only the controller user side is driven; it, the dll flags and a few link pins are read
`timescale 1ns/100ps
module sync_sram_init_and_burst_ops_tb;
    import sqd_pkg::*;
    localparam int LK = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic clk_stop = 1'b0;
    logic single_clk = 1'b0;
    logic dll_off = 1'b0;
    logic dll_reset_req = 1'b0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    sqd_addr_t rd_addr = 20'h00000;
    sqd_addr_t wr_addr = 20'h00000;
    sqd_data_t wr_d0 = 36'h000000000;
    sqd_data_t wr_d1 = 36'h000000000;
    logic ready, cmd_ack, rd_done, dll_ready, dll_on;
    sqd_data_t rd_d0, rd_d1;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int lat_on, lat_off, n;

    // ==========================================================
    // the two ends face each other across one interface
    sqd_link_if link ();
    sqd_dev #(.LOCK_CYCLES(LK)) u_sqd_dev (.mclk(mclk), .rst(rst),
        .link(link.dev), .dll_ready(dll_ready), .dll_on(dll_on));
    sqd_ctl #(.LOCK_CYCLES(LK)) u_sqd_ctl (.mclk(mclk), .rst(rst),
        .link(link.ctl), .clk_stop(clk_stop), .single_clk(single_clk),
        .dll_off(dll_off), .dll_reset_req(dll_reset_req),
        .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_d0(wr_d0), .wr_d1(wr_d1), .ready(ready),
        .cmd_ack(cmd_ack), .rd_done(rd_done), .rd_d0(rd_d0), .rd_d1(rd_d1));
    sqd_link_properties u_sqd_link_properties (.mclk(mclk), .rst(rst),
        .k(link.k), .kn(link.kn), .c(link.c), .cn(link.cn),
        .r_n(link.r_n), .w_n(link.w_n), .doff_n(link.doff_n),
        .addr(link.addr), .d(link.d), .q(link.q), .q_vld(link.q_vld),
        .q_new(link.q_new));

    // ==========================================================
    // clock and hang guard, ceiling well above six lock waits
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input sqd_data_t got, input sqd_data_t exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time,
                got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // sampled 1 ns after the edge so that edge's updates have landed
    task automatic wait_lvl(ref logic s, input logic v, input int lim,
                            output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (s !== v && cnt < lim);
        chk(36'(s), 36'(v));
    endtask

    // requests are held until the ack, then dropped on the next edge
    task automatic do_op(input logic rd, input logic wr,
        input sqd_addr_t ra, input sqd_addr_t wa, input sqd_data_t w0,
        input sqd_data_t w1, input sqd_data_t e0, input sqd_data_t e1,
        output int lat);
        int m;
        @(posedge mclk);
        rd_req <= rd;
        wr_req <= wr;
        rd_addr <= ra;
        wr_addr <= wa;
        wr_d0 <= w0;
        wr_d1 <= w1;
        wait_lvl(cmd_ack, 1'b1, 8, m);
        @(posedge mclk);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        lat = 0;
        if (rd) begin
            wait_lvl(rd_done, 1'b1, 20, lat);
            chk(rd_d0, e0);
            chk(rd_d1, e1);
        end
    endtask

    // relock after any dll reset must take the whole lock wait
    task automatic relock();
        wait_lvl(dll_ready, 1'b0, 20, n);
        wait_lvl(dll_ready, 1'b1, 3000, n);
        chk(36'(n >= LK * 4 - 4), 36'h1);
        wait_lvl(ready, 1'b1, 3000, n);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_bursts();
        do_op(1'b0, 1'b1, 0, 3, 36'hA5A5A0003, 36'h5A5A50004, 0, 0, n);
        do_op(1'b1, 1'b0, 3, 0, 0, 0, 36'hA5A5A0003, 36'h5A5A50004, lat_on);
        do_op(1'b0, 1'b1, 0, 15, 36'hC3C3C000F, 36'h3C3C30000, 0, 0, n);
        do_op(1'b1, 1'b0, 15, 0, 0, 0, 36'hC3C3C000F, 36'h3C3C30000, n);
        do_op(1'b1, 1'b1, 3, 7, 36'h123450007, 36'h678900008,
            36'hA5A5A0003, 36'h5A5A50004, n);
        do_op(1'b1, 1'b0, 7, 0, 0, 0, 36'h123450007, 36'h678900008, n);
    endtask

    task automatic t_dll_off();
        @(posedge mclk);
        dll_off <= 1'b1;
        wait_lvl(dll_on, 1'b0, 20, n);
        wait_lvl(dll_ready, 1'b1, 3000, n);
        wait_lvl(ready, 1'b1, 3000, n);
        do_op(1'b1, 1'b0, 3, 0, 0, 0, 36'hA5A5A0003, 36'h5A5A50004, lat_off);
        // last beat moves from t+2.0 to t+1.5: half a K period
        chk(36'(lat_on - lat_off), 36'(K_HALF));
        @(posedge mclk);
        dll_off <= 1'b0;
        relock();
        do_op(1'b1, 1'b0, 7, 0, 0, 0, 36'h123450007, 36'h678900008, n);
    endtask

    task automatic t_resets();
        @(posedge mclk);
        clk_stop <= 1'b1;
        repeat (6) @(posedge mclk);
        clk_stop <= 1'b0;
        wait_lvl(dll_ready, 1'b0, 10, n);
        wait_lvl(dll_ready, 1'b1, 3000, n);
        wait_lvl(ready, 1'b1, 3000, n);
        do_op(1'b1, 1'b0, 15, 0, 0, 0, 36'hC3C3C000F, 36'h3C3C30000, n);
        // output clocks tied high together with a dll reset, as a restart would do
        @(posedge mclk);
        single_clk <= 1'b1;
        dll_reset_req <= 1'b1;
        @(posedge mclk);
        dll_reset_req <= 1'b0;
        relock();
        chk(36'({link.c, link.cn}), 36'h3);
        do_op(1'b1, 1'b0, 3, 0, 0, 0, 36'hA5A5A0003, 36'h5A5A50004, n);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        // select and K pins at their defined levels while reset holds
        chk(36'({link.r_n, link.w_n, link.k, link.kn}), 36'hD);
        rst <= 1'b0;
        // K starts half a period in, then LK rises of stable clock
        wait_lvl(ready, 1'b1, 3000, n);
        chk(36'(n), 36'((2 * LK - 1) * K_HALF));
        // the memory end counts the same rises behind its pin filter
        wait_lvl(dll_ready, 1'b1, 20, n);
        chk(36'({dll_ready, dll_on}), 36'h3);
        t_bursts();
        t_dll_off();
        t_resets();
        tally_and_finish();
    end
endmodule // sync_sram_init_and_burst_ops_tb
